/* File: verilog/swdt_pkg.sv */
// Purpose: Shared constants and types for the system watchdog timer
// Assumes: Core clock 250 MHz; low-frequency oscillator tick arrives as an async level
// Notes: Register offsets on the plain register port are local choices
package swdt_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_WDCTL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RCAUSE = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_CSTAT = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h4;
    // Control register layout
    localparam int PS_LSB = 1;
    localparam int PS_MSB = 5;
    localparam int SWEN_BIT = 0;
    localparam logic [DATA_W-1:0] WDCTL_RST = 8'h16;
    // Mode field position in the low byte of config word one
    localparam int MODE_LSB = 3;
    localparam int MODE_MSB = 4;
    // Core status and reset cause flag positions
    localparam int TO_BIT = 4;
    localparam int PD_BIT = 3;
    localparam int WATCHDOG_RESET_FLAG_N_BIT = 4;
    // Period select limits
    localparam logic [4:0] PS_MAX = 5'h12;
    localparam int PRE_BASE_LOG2 = 5;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
    // Time base
    localparam int LFOSC_HZ = 31000;
    localparam int BASE_TICK_MS = 1;
    // Interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_RESET = 0;
    localparam int IRQ_WAKE = 1;

    typedef enum logic [1:0] {
        SWDT_OFF = 2'b00,
        SWDT_SW = 2'b01,
        SWDT_NOSLEEP = 2'b10,
        SWDT_ON = 2'b11
    } swdt_mode_e;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } swdt_req_s;

    // Core events seen by the watchdog
    typedef struct packed {
        logic clr_instr;
        logic sleep_enter;
        logic sleep_exit;
        logic osc_fail;
    } swdt_evt_s;
endpackage : swdt_pkg

/* File: verilog/swdt_sync.sv */
// Purpose: Two-flop synchroniser with rising edge pulse
// Assumes: Input is asynchronous to the core clock
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
module swdt_sync
    import swdt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_async,
    output logic o_rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Two-flop crossing then edge history
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (i_ce) begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign o_rise = i_ce & s2_q & ~s3_q; // One tick per oscillator rising edge
endmodule : swdt_sync
`default_nettype wire

/* File: verilog/swdt_irq.sv */
// Purpose: Sticky event status with mask and level interrupt
// Assumes: Write one to clear; set wins over clear
// Notes: Output comes from a flop
`timescale 1ns/1ns
`default_nettype none
module swdt_irq
    import swdt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [IRQ_W-1:0] i_evt,
    input wire logic [IRQ_W-1:0] i_w1c,
    input wire logic i_mask_wr,
    input wire logic [IRQ_W-1:0] i_mask_d,
    output logic [IRQ_W-1:0] o_stat,
    output logic [IRQ_W-1:0] o_mask,
    output logic o_irq
);
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic irq_q;

    // Sticky bits, event beats clear
    genvar g;
    generate
        for (g = 0; g < IRQ_W; g++) begin : g_bit
            always_ff @(posedge i_core_clk) begin
                if (i_srst) begin
                    stat_q[g] <= 1'b0;
                end else if (i_ce) begin
                    stat_q[g] <= i_evt[g] | (stat_q[g] & ~i_w1c[g]);
                end
            end
        end
    endgenerate

    // Mask and registered interrupt level
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mask_q <= '0;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            if (i_mask_wr) begin
                mask_q <= i_mask_d;
            end
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign o_stat = stat_q;
    assign o_mask = mask_q;
    assign o_irq = irq_q;
endmodule : swdt_irq
`default_nettype wire

/* File: verilog/swdt_top.sv */
// Purpose: System watchdog timer with sleep wake and reset cause flags
// Assumes: Core events are one-cycle pulses on the core clock; oscillator is async
// Notes: One count per oscillator tick; prescaler and counter form one chain
`timescale 1ns/1ns
`default_nettype none
// Contract
// - The count advances once per tick of the 31 kHz low-frequency oscillator, 1 ms per base step.
// - The mode comes from bits 4 and 3 of the low byte of config word one.
// - Mode 11 keeps the watchdog active always, Sleep included, ignoring the software enable.
// - Mode 10 keeps it active while awake and disabled in Sleep.
// - Mode 01 runs it exactly while the software enable is one, regardless of Sleep.
// - Mode 00 disables it for good, and the software enable only matters in mode 01.
// - Active and not cleared before the period ends, the watchdog resets the system.
// - Period select code n gives a ratio of 32 times two to the n, from 1 ms to 256 s.
// - Codes 10011 to 11111 behave as the minimum 1:32 ratio.
// - Any reset loads period select 01011, a 1:65536 ratio of two seconds.
// - Reset, clear instruction, Sleep entry and exit, oscillator failure and disabling clear the count.
// - Changing the internal oscillator divider leaves the count alone.
// - Sleep entry clears the count, counting restarts from zero if still active, Sleep exit clears again.
// - A time-out in Sleep gives no reset but wakes the device.
// - A watchdog event updates the time-out and power-down flags and the reset cause flag; a time-out in Sleep leaves the reset cause flag unchanged.
// - The control register reads bits 7 and 6 as zero, period in bits 5 to 1, enable in bit 0, reset 16h.
module swdt_top
    import swdt_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_low_freq_osc,
    input wire logic [7:0] i_config_word_one,
    input wire logic i_sleeping,
    input wire logic i_clear_watchdog_instr,
    input wire logic i_sleep_enter,
    input wire logic i_sleep_exit,
    input wire logic i_osc_fail,
    input wire logic [3:0] i_int_osc_divider,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_sys_reset,
    output logic o_wake,
    output logic o_timeout_flag_n,
    output logic o_powerdown_flag_n,
    output logic o_watchdog_reset_flag_n,
    output logic o_irq
);
    swdt_req_s req;
    swdt_evt_s evt;
    swdt_mode_e mode;
    logic [4:0] ps_q;
    logic swen_q;
    logic [CNT_W-1:0] cnt_q;
    logic active;
    logic active_q;
    logic tick;
    logic timeout;
    logic clr_cnt;
    logic to_n_q;
    logic pd_n_q;
    logic watchdog_reset_flag_n_n_q;
    logic sysrst_q;
    logic wake_q;
    logic [DATA_W-1:0] rdata_q;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq_w;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_w1c;
    logic mask_wr;

    // Base step length in oscillator ticks, for reference
    localparam int TICKS_PER_MS = (LFOSC_HZ * BASE_TICK_MS) / 1000;

    // Period code to terminal count, reserved codes fold to minimum
    function automatic logic [CNT_W-1:0] last_count(input logic [4:0] code);
        logic [4:0] eff;
        eff = (code > PS_MAX) ? 5'h00 : code;
        last_count = (CNT_ONE << (PRE_BASE_LOG2 + int'(eff))) - CNT_ONE;
    endfunction : last_count

    // Request bundle and core events
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign evt = '{clr_instr: i_clear_watchdog_instr, sleep_enter: i_sleep_enter,
                   sleep_exit: i_sleep_exit, osc_fail: i_osc_fail};
    assign mode = swdt_mode_e'(i_config_word_one[MODE_MSB:MODE_LSB]);

    // Oscillator tick crosses into the core clock
    swdt_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_async(i_low_freq_osc),
        .o_rise(tick)
    );

    // Mode table decides whether the watchdog runs
    always_comb begin
        case (mode)
            SWDT_ON: active = 1'b1;
            SWDT_NOSLEEP: active = ~i_sleeping;
            SWDT_SW: active = swen_q;
            SWDT_OFF: active = 1'b0;
            default: active = 1'b0;
        endcase
    end

    // Clearing sources; divider input deliberately unused here
    assign clr_cnt = evt.clr_instr | evt.sleep_enter | evt.sleep_exit
                     | evt.osc_fail | ~active;
    assign timeout = active & tick & (cnt_q == last_count(ps_q)) & ~clr_cnt;

    // Control register, reset loads 16h
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ps_q <= WDCTL_RST[PS_MSB:PS_LSB];
            swen_q <= WDCTL_RST[SWEN_BIT];
        end else if (i_ce && req.wr && req.addr == OFF_WDCTL) begin
            ps_q <= req.wdata[PS_MSB:PS_LSB];
            swen_q <= req.wdata[SWEN_BIT];
        end
    end

    // Prescaler and counter chain
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cnt_q <= '0;
            active_q <= 1'b0;
        end else if (i_ce) begin
            active_q <= active;
            if (clr_cnt || timeout) begin
                cnt_q <= '0;
            end else if (tick) begin
                cnt_q <= cnt_q + CNT_ONE;
            end
        end
    end

    // Reset or wake on time-out
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sysrst_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (i_ce) begin
            sysrst_q <= timeout & ~i_sleeping;
            wake_q <= timeout & i_sleeping;
        end
    end

    // Status flags: time-out and power-down, active low
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
        end else if (i_ce) begin
            if (timeout) begin
                to_n_q <= 1'b0;
                pd_n_q <= ~i_sleeping;
            end else if (evt.clr_instr) begin
                to_n_q <= 1'b1;
                pd_n_q <= 1'b1;
            end else if (evt.sleep_enter) begin
                to_n_q <= 1'b1;
                pd_n_q <= 1'b0;
            end
        end
    end

    // Reset cause flag survives the watchdog's own system reset
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            watchdog_reset_flag_n_n_q <= 1'b1;
        end else if (i_ce) begin
            if (timeout && !i_sleeping) begin
                watchdog_reset_flag_n_n_q <= 1'b0;
            end else if (req.wr && req.addr == OFF_RCAUSE && req.wdata[WATCHDOG_RESET_FLAG_N_BIT]) begin
                watchdog_reset_flag_n_n_q <= 1'b1;
            end
        end
    end

    // Interrupt events and controls
    assign irq_evt[IRQ_RESET] = timeout & ~i_sleeping;
    assign irq_evt[IRQ_WAKE] = timeout & i_sleeping;
    assign irq_w1c = (req.wr && req.addr == OFF_IRQ_STAT) ? req.wdata[IRQ_W-1:0] : '0;
    assign mask_wr = req.wr && req.addr == OFF_IRQ_MASK;

    swdt_irq u_irq (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_evt(irq_evt),
        .i_w1c(irq_w1c),
        .i_mask_wr(mask_wr),
        .i_mask_d(req.wdata[IRQ_W-1:0]),
        .o_stat(irq_stat),
        .o_mask(irq_mask),
        .o_irq(irq_w)
    );

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rdata_q <= '0;
        end else if (i_ce) begin
            rdata_q <= '0;
            if (req.rd) begin
                case (req.addr)
                    OFF_WDCTL: rdata_q <= {2'b00, ps_q, swen_q};
                    OFF_RCAUSE: rdata_q <= DATA_W'(watchdog_reset_flag_n_n_q) << WATCHDOG_RESET_FLAG_N_BIT;
                    OFF_CSTAT: rdata_q <= (DATA_W'(to_n_q) << TO_BIT)
                                          | (DATA_W'(pd_n_q) << PD_BIT);
                    OFF_IRQ_STAT: rdata_q <= DATA_W'(irq_stat);
                    OFF_IRQ_MASK: rdata_q <= DATA_W'(irq_mask);
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_sys_reset = sysrst_q;
    assign o_wake = wake_q;
    assign o_timeout_flag_n = to_n_q;
    assign o_powerdown_flag_n = pd_n_q;
    assign o_watchdog_reset_flag_n = watchdog_reset_flag_n_n_q;
    assign o_irq = irq_w;

    // Checks
    AST_OFF_NEVER_FIRES: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (mode == SWDT_OFF) |-> !timeout) else $error("time-out while mode off");
    AST_NOSLEEP_IDLE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (mode == SWDT_NOSLEEP && i_sleeping && i_ce) |=> cnt_q == '0)
        else $error("count moved in sleep with mode 10");
    AST_SW_FOLLOWS: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (mode == SWDT_SW) |-> active == swen_q) else $error("mode 01 ignores enable");
    AST_ALWAYS_ON: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (mode == SWDT_ON) |-> active) else $error("mode 11 not active");
    AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && (evt.clr_instr || evt.sleep_enter || evt.osc_fail)) |=> cnt_q == '0)
        else $error("count not cleared");
    AST_RESET_AWAKE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && timeout && !i_sleeping) |=> o_sys_reset && !o_wake && !o_timeout_flag_n)
        else $error("awake time-out gave no reset");
    AST_WAKE_SLEEP: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && timeout && i_sleeping) |=> o_wake && !o_sys_reset && !o_powerdown_flag_n)
        else $error("sleep time-out did not wake");
    AST_RESERVED_MIN: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (ps_q > PS_MAX) |-> last_count(ps_q) == last_count(5'h00))
        else $error("reserved code not minimum");
    AST_CTL_RESET: assert property (@(posedge i_core_clk)
        i_srst |=> {ps_q, swen_q} == WDCTL_RST[PS_MSB:0]) else $error("bad control reset");
    AST_WATCHDOG_RESET_FLAG_N_LOW: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && timeout && !i_sleeping) |=> !o_watchdog_reset_flag_n)
        else $error("reset flag not driven low");
    // Mode 01 with enable low keeps the count at zero
    AST_SW_OFF_IDLE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && mode == SWDT_SW && !swen_q) |=> cnt_q == '0)
        else $error("count moved with software enable low");
    // Mode 00 keeps the count at zero
    AST_OFF_IDLE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && mode == SWDT_OFF) |=> cnt_q == '0)
        else $error("count moved with mode off");
    // Leaving Sleep clears the count
    AST_EXIT_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && evt.sleep_exit) |=> cnt_q == '0)
        else $error("count not cleared on sleep exit");
    // Disabled watchdog holds the count at zero
    AST_DISABLE_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && !active) |=> cnt_q == '0)
        else $error("count not cleared while disabled");
    // One step per oscillator tick
    AST_STEP: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && tick && !clr_cnt && !timeout) |=> cnt_q == $past(cnt_q) + CNT_ONE)
        else $error("count did not step on tick");
    // No tick and no clear leaves the count alone, whatever the divider does
    AST_HOLD: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && !tick && !clr_cnt) |=> $stable(cnt_q))
        else $error("count moved without a tick");
    // Terminal count on a tick ends the period
    AST_END_OF_PERIOD: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && active && tick && !clr_cnt && cnt_q == last_count(ps_q))
        |=> cnt_q == '0 && (o_sys_reset || o_wake))
        else $error("terminal count gave no event");
    // Reset and wake never together
    AST_NOT_BOTH: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !(o_sys_reset && o_wake)) else $error("reset and wake together");
    // Reset pulse lasts one cycle
    AST_RESET_PULSE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && o_sys_reset) |=> !o_sys_reset)
        else $error("reset pulse too long");
    // Wake pulse lasts one cycle
    AST_WAKE_PULSE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && o_wake) |=> !o_wake)
        else $error("wake pulse too long");
    // Clear instruction raises both status flags
    AST_TO_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && evt.clr_instr && !timeout) |=> o_timeout_flag_n && o_powerdown_flag_n)
        else $error("flags not set by clear instruction");
    // Sleep entry drops power-down flag
    AST_SLEEP_PD: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && evt.sleep_enter && !timeout && !evt.clr_instr)
        |=> !o_powerdown_flag_n && o_timeout_flag_n)
        else $error("power-down flag not low after sleep entry");
    // Writing one to the cause bit sets the flag again
    AST_WATCHDOG_RESET_FLAG_N_SET: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && !timeout && req.wr && req.addr == OFF_RCAUSE && req.wdata[WATCHDOG_RESET_FLAG_N_BIT])
        |=> o_watchdog_reset_flag_n)
        else $error("reset flag not set by write");
    // Control write lands in the next cycle
    AST_PS_WRITE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && req.wr && req.addr == OFF_WDCTL)
        |=> ps_q == $past(req.wdata[PS_MSB:PS_LSB]) && swen_q == $past(req.wdata[SWEN_BIT]))
        else $error("control write lost");
    // Unused control bits read as zero
    AST_CTL_TOP_ZERO: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && req.rd && req.addr == OFF_WDCTL) |=> o_rdata[7:6] == 2'b00)
        else $error("control top bits not zero");
    // Read data is zero outside the answer cycle
    AST_RDATA_IDLE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && !req.rd) |=> o_rdata == '0)
        else $error("read data not zero when idle");
    // Any reset leaves flags high and pulses low
    AST_RESET_FLAGS: assert property (@(posedge i_core_clk)
        i_srst |=> o_timeout_flag_n && o_powerdown_flag_n && !o_sys_reset && !o_wake)
        else $error("bad flag reset");
    // Clock enable low freezes the count and control
    AST_CE_FREEZE: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !i_ce |=> $stable(cnt_q) && $stable(ps_q) && $stable(swen_q))
        else $error("state moved with clock enable low");
    // Interrupt level follows status and mask one cycle later
    AST_IRQ_LEVEL: assert property (@(posedge i_core_clk) disable iff (i_srst)
        i_ce |=> o_irq == $past(|(irq_stat & irq_mask)))
        else $error("interrupt level wrong");
    // Terminal count cannot come on a clear cycle
    AST_CLEAR_WINS: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_ce && clr_cnt) |=> !o_sys_reset && !o_wake)
        else $error("event despite clear");
    COV_RESET: cover property (@(posedge i_core_clk) disable iff (i_srst) o_sys_reset);
    COV_WAKE: cover property (@(posedge i_core_clk) disable iff (i_srst) o_wake);
    COV_CLR: cover property (@(posedge i_core_clk) disable iff (i_srst)
        active && evt.clr_instr && cnt_q != '0);
    COV_DISABLE: cover property (@(posedge i_core_clk) disable iff (i_srst)
        active_q && !active);
    COV_RESERVED: cover property (@(posedge i_core_clk) disable iff (i_srst)
        ps_q > PS_MAX && o_sys_reset);
endmodule : swdt_top
`default_nettype wire

/* File: test/swdt_core_model.sv */
// Purpose: Core-side model: firmware clears, sleep control and the free oscillator
// Assumes: Oscillator runs free and has no phase relation to the core clock
// Notes: Bench commands are one-cycle pulses; a wake pulse ends Sleep by itself
`timescale 1ns/1ns
`default_nettype none
module swdt_core_model (
    input wire logic i_core_clk,
    input wire logic i_do_clear,
    input wire logic i_do_sleep,
    input wire logic i_do_exit,
    input wire logic i_wake,
    output logic o_low_freq_osc,
    output logic o_clear_watchdog_instr,
    output logic o_sleep_enter,
    output logic o_sleep_exit,
    output logic o_sleeping
);
    // Start quiet, awake
    initial begin
        o_low_freq_osc = 1'b0;
        o_clear_watchdog_instr = 1'b0;
        o_sleep_enter = 1'b0;
        o_sleep_exit = 1'b0;
        o_sleeping = 1'b0;
    end
    // Fast stand-in for the low-frequency oscillator, odd half period
    always #31 o_low_freq_osc = ~o_low_freq_osc;
    // Firmware clear instruction when commanded
    always @(posedge i_core_clk) begin
        o_clear_watchdog_instr <= i_do_clear;
    end
    // Sleep entry, resume on wake or command
    always @(posedge i_core_clk) begin
        o_sleep_enter <= i_do_sleep && !o_sleeping;
        o_sleep_exit <= o_sleeping && (i_wake || i_do_exit);
        if (i_do_sleep) begin
            o_sleeping <= 1'b1;
        end else if (i_wake || i_do_exit) begin
            o_sleeping <= 1'b0;
        end
    end
endmodule : swdt_core_model
`default_nettype wire

/* File: test/swdt_top_tb_top.sv */
// Purpose: Self-checking bench for the watchdog top
// Assumes: Oscillator model period of about 15.5 core cycles
// Notes: Reads and events are queued by the driver and checked by a monitor
`timescale 1ns/1ns
`default_nettype none
module swdt_top_tb_top;
    import swdt_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] cfg = 8'h18;
    logic [3:0] div = 4'h0;
    logic [3:0] cmd = 4'h0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_seen = 1'b0;
    logic osc_q = 1'b0;
    logic osc, clr_w, ent_w, ext_w, slp_w, sys_rst, wake, to_n, pd_n, rw_n, irq;
    logic [DATA_W-1:0] rdata;
    logic [31:0] seed = 32'hb097_0a28;
    logic [4:0] code;
    int ticks = 0;
    int tk;
    int miscompares = 0;
    int n_tests = 0;
    logic [DATA_W-1:0] exp_rd[$];
    logic [1:0] exp_ev[$];
    int exp_tk[$];

    always #2 clk = ~clk;

    swdt_core_model core (.i_core_clk(clk), .i_do_clear(cmd[0]), .i_do_sleep(cmd[1]),
        .i_do_exit(cmd[2]), .i_wake(wake), .o_low_freq_osc(osc),
        .o_clear_watchdog_instr(clr_w), .o_sleep_enter(ent_w), .o_sleep_exit(ext_w),
        .o_sleeping(slp_w));

    swdt_top dut (.i_core_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_low_freq_osc(osc),
        .i_config_word_one(cfg), .i_sleeping(slp_w), .i_clear_watchdog_instr(clr_w),
        .i_sleep_enter(ent_w), .i_sleep_exit(ext_w), .i_osc_fail(cmd[3]),
        .i_int_osc_divider(div), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_sys_reset(sys_rst), .o_wake(wake), .o_timeout_flag_n(to_n),
        .o_powerdown_flag_n(pd_n), .o_watchdog_reset_flag_n(rw_n), .o_irq(irq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One register cycle; a read notes its expected data
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        if (!w) exp_rd.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    // One-cycle command: bit0 clear, bit1 sleep, bit2 sleep exit, bit3 oscillator fail
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        cmd <= m;
        @(posedge clk);
        cmd <= 4'h0;
    endtask : pulse

    // Set mode and control, restart via m, expect event k after n ticks or none
    task automatic run(input logic [7:0] c, input logic [7:0] ctl, input int n,
        input logic [1:0] k, input logic [3:0] m);
        seed = xs(seed);
        cfg <= c | (seed[7:0] & 8'he7);
        bus(1'b1, OFF_WDCTL, ctl);
        pulse(m);
        if (k != 2'b00) begin
            exp_ev.push_back(k);
            exp_tk.push_back(n);
        end
        repeat (n * 16 + 120) begin
            @(posedge clk);
            seed = xs(seed);
            div <= seed[3:0];
        end
        chk("missing event", 8'h00, 8'(exp_ev.size()));
        exp_ev.delete();
        exp_tk.delete();
    endtask : run

    // Monitor: oscillator rises since last clear, read data and time-out events
    always @(posedge clk) begin
        osc_q <= osc;
        if (clr_w || ent_w || ext_w || cmd[3]) begin
            ticks <= 0;
        end else if (osc && !osc_q) begin
            ticks <= ticks + 1;
        end
        rd_seen <= rd;
        if (rd_seen) chk("rdata", exp_rd.pop_front(), rdata);
        if (sys_rst || wake) begin
            if (exp_ev.size() == 0) begin
                chk("unexpected event", 8'h00, {6'h00, wake, sys_rst});
            end else begin
                chk("event kind", {6'h00, exp_ev.pop_front()}, {6'h00, wake, sys_rst});
                tk = exp_tk.pop_front();
                chk("ticks", 8'(tk), (ticks == tk - 1) ? 8'(tk) : 8'(ticks));
            end
        end
    end

    // Hang guard
    initial begin
        #200_000;
        miscompares++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, OFF_WDCTL, WDCTL_RST);
        bus(1'b0, OFF_CSTAT, 8'h18);
        bus(1'b0, OFF_RCAUSE, 8'h10);
        bus(1'b0, 4'hf, 8'h00);
        bus(1'b1, OFF_WDCTL, 8'hff);
        bus(1'b0, OFF_WDCTL, 8'h3f);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, OFF_WDCTL, WDCTL_RST);
        bus(1'b1, OFF_IRQ_MASK, 8'h00);
        run(8'h18, 8'h00, 32, 2'b01, 4'h1);
        chk("timeout_n", 8'h00, {7'h00, to_n});
        chk("reset_flag_n", 8'h00, {7'h00, rw_n});
        chk("irq masked", 8'h00, {7'h00, irq});
        bus(1'b0, OFF_CSTAT, 8'h08);
        bus(1'b0, OFF_RCAUSE, 8'h00);
        bus(1'b0, OFF_IRQ_STAT, 8'h01);
        bus(1'b1, OFF_IRQ_MASK, 8'h03);
        repeat (3) @(posedge clk);
        #1 chk("irq raised", 8'h01, {7'h00, irq});
        bus(1'b1, OFF_IRQ_STAT, 8'h01);
        repeat (3) @(posedge clk);
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
        bus(1'b1, OFF_RCAUSE, 8'h10);
        bus(1'b0, OFF_RCAUSE, 8'h10);
        run(8'h18, 8'h02, 64, 2'b01, 4'h1);
        seed = xs(seed);
        code = 5'h13 + 5'(seed % 13);
        run(8'h18, {2'b00, code, 1'b0}, 32, 2'b01, 4'h1);
        run(8'h18, 8'h3e, 32, 2'b01, 4'h1);
        repeat (4) run(8'h18, 8'h00, 16, 2'b00, 4'h1);
        run(8'h18, 8'h00, 32, 2'b01, 4'h8);
        run(8'h18, 8'h00, 16, 2'b00, 4'h1);
        run(8'h18, 8'h00, 32, 2'b10, 4'h2);
        chk("powerdown_n", 8'h00, {7'h00, pd_n});
        bus(1'b0, OFF_CSTAT, 8'h00);
        bus(1'b0, OFF_IRQ_STAT, 8'h03);
        bus(1'b1, OFF_IRQ_STAT, 8'h03);
        run(8'h10, 8'h00, 40, 2'b00, 4'h2);
        run(8'h10, 8'h00, 32, 2'b01, 4'h4);
        run(8'h08, 8'h00, 40, 2'b00, 4'h1);
        run(8'h08, 8'h01, 32, 2'b01, 4'h1);
        run(8'h08, 8'h01, 32, 2'b10, 4'h2);
        run(8'h00, 8'h01, 40, 2'b00, 4'h1);
        test_done();
    end
endmodule : swdt_top_tb_top
`default_nettype wire
